/* File: logic/bidir_port_b_pins.sv */
`timescale 1ns/100ps
`default_nettype none
module bidir_port_b_pins (
  input  wire logic                              aclk,
  input  wire logic                              aresetn,
  input  wire logic                              s_axi_awvalid,
  output logic                                   s_axi_awready,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  s_axi_awaddr,
  input  wire logic                              s_axi_wvalid,
  output logic                                   s_axi_wready,
  input  wire logic [31:0]                       s_axi_wdata,
  input  wire logic [3:0]                        s_axi_wstrb,
  output logic                                   s_axi_bvalid,
  input  wire logic                              s_axi_bready,
  output logic      [1:0]                        s_axi_bresp,
  input  wire logic                              s_axi_arvalid,
  output logic                                   s_axi_arready,
  input  wire logic [gpio_port_pkg::ADDR_W-1:0]  s_axi_araddr,
  output logic                                   s_axi_rvalid,
  input  wire logic                              s_axi_rready,
  output logic      [31:0]                       s_axi_rdata,
  output logic      [1:0]                        s_axi_rresp,
  input  wire logic [7:0]                        pad_in,
  output logic      [7:0]                        pad_out,
  output logic      [7:0]                        pad_oe,
  output logic      [7:0]                        pad_pullup,
  output logic      [7:0]                        pad_schmitt,
  input  wire logic                              prog_mode_in,
  input  wire logic                              prog_data_drive,
  input  wire logic                              prog_data_oe,
  output logic                                   prog_clock,
  output logic                                   prog_data,
  output logic                                   irq
);

  logic [8:0] sync_all;
  logic [7:0] pins;
  logic       prog;

  pin_sync3 #(.W(9)) u_sync (
    .aclk     (aclk),
    .aresetn  (aresetn),
    .async_in ({prog_mode_in, pad_in}),
    .sync_out (sync_all)
  );
  assign pins = sync_all[7:0];
  assign prog = sync_all[8];

  // register state
  logic [7:0]           latch_q, latch_d;
  logic [7:0]           dir_q, dir_d;
  gpio_port_pkg::ctrl_t ctrl_q, ctrl_d;
  gpio_port_pkg::irq_t  stat_q, stat_d, mask_q, mask_d;
  logic [7:0]           prev_q;
  // bus state
  logic                              aw_full_q, aw_full_d, w_full_q, w_full_d;
  logic [gpio_port_pkg::ADDR_W-1:0]  aw_addr_q, aw_addr_d;
  logic [7:0]                        w_data_q, w_data_d;
  logic                              w_en_q, w_en_d;
  logic                              bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]                        bresp_q, bresp_d, rresp_q, rresp_d;
  logic [31:0]                       rdata_q, rdata_d;
  logic                              awready_q, awready_d, wready_q, wready_d;
  logic                              arready_q, arready_d;
  // pin side outputs
  logic [7:0] out_q, out_d, oe_q, oe_d, pull_q, pull_d, schm_q, schm_d;
  logic       pclk_q, pclk_d, pdat_q, pdat_d, irq_q, irq_d;

  logic                do_wr;
  logic [2:0]          bit_idx;
  logic [7:0]          rmw;
  gpio_port_pkg::irq_t ev, clr;
  logic                ext_edge;

  always_comb begin
    do_wr   = aw_full_q && w_full_q && !bvalid_q;
    bit_idx = w_data_q[gpio_port_pkg::BITOP_IDX_HI:gpio_port_pkg::BITOP_IDX_LO];
    rmw     = pins;
    rmw[bit_idx] = w_data_q[gpio_port_pkg::BITOP_VAL];
    ext_edge = ctrl_q.edge_rise ? (pins[gpio_port_pkg::EXT_PIN] && !prev_q[gpio_port_pkg::EXT_PIN])
                                : (!pins[gpio_port_pkg::EXT_PIN] && prev_q[gpio_port_pkg::EXT_PIN]);
    ev.ext    = ctrl_q.ext_int_sel && ext_edge;
    ev.change = |((pins[gpio_port_pkg::CHG_HI:gpio_port_pkg::CHG_LO]
                   ^ prev_q[gpio_port_pkg::CHG_HI:gpio_port_pkg::CHG_LO])
                  & dir_q[gpio_port_pkg::CHG_HI:gpio_port_pkg::CHG_LO]);
    clr       = '0;
    latch_d   = latch_q;
    dir_d     = dir_q;
    ctrl_d    = ctrl_q;
    mask_d    = mask_q;
    if (do_wr && w_en_q) begin
      case (aw_addr_q)
        gpio_port_pkg::OFS_PORT:   latch_d = w_data_q;
        gpio_port_pkg::OFS_DIR:    dir_d   = w_data_q;
        gpio_port_pkg::OFS_CTRL:   ctrl_d  = w_data_q[2:0];
        gpio_port_pkg::OFS_BITOP:  latch_d = rmw;
        gpio_port_pkg::OFS_STATUS: clr     = w_data_q[1:0];
        gpio_port_pkg::OFS_MASK:   mask_d  = w_data_q[1:0];
        default:                   ;
      endcase
    end
    // a fresh event beats a clear in the same cycle
    stat_d = (stat_q & ~clr) | ev;
  end

  always_comb begin
    aw_full_d = aw_full_q;
    aw_addr_d = aw_addr_q;
    w_full_d  = w_full_q;
    w_data_d  = w_data_q;
    w_en_d    = w_en_q;
    bvalid_d  = bvalid_q;
    bresp_d   = bresp_q;
    rvalid_d  = rvalid_q;
    rresp_d   = rresp_q;
    rdata_d   = rdata_q;
    if (s_axi_awvalid && awready_q) begin
      aw_full_d = 1'b1;
      aw_addr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && wready_q) begin
      w_full_d = 1'b1;
      w_data_d = s_axi_wdata[7:0];
      w_en_d   = s_axi_wstrb[0];
    end
    if (do_wr) begin
      aw_full_d = 1'b0;
      w_full_d  = 1'b0;
      bvalid_d  = 1'b1;
      bresp_d   = (aw_addr_q <= gpio_port_pkg::OFS_MASK && aw_addr_q[1:0] == 2'h0)
                  ? gpio_port_pkg::RESP_OKAY : gpio_port_pkg::RESP_SLVERR;
    end else if (bvalid_q && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    if (s_axi_arvalid && arready_q) begin
      rvalid_d = 1'b1;
      rresp_d  = gpio_port_pkg::RESP_OKAY;
      rdata_d  = 32'h0000_0000;
      case (s_axi_araddr)
        gpio_port_pkg::OFS_PORT:   rdata_d[7:0] = pins;
        gpio_port_pkg::OFS_DIR:    rdata_d[7:0] = dir_q;
        gpio_port_pkg::OFS_CTRL:   rdata_d[2:0] = ctrl_q;
        gpio_port_pkg::OFS_BITOP:  rdata_d[7:0] = latch_q;
        gpio_port_pkg::OFS_STATUS: rdata_d[1:0] = stat_q;
        gpio_port_pkg::OFS_MASK:   rdata_d[1:0] = mask_q;
        default:                   rresp_d      = gpio_port_pkg::RESP_SLVERR;
      endcase
    end else if (rvalid_q && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    awready_d = !aw_full_d;
    wready_d  = !w_full_d;
    arready_d = !rvalid_d;
  end

  // pin drivers, all registered so the pads see no decode glitches
  always_comb begin
    oe_d   = ~dir_q;
    out_d  = latch_q;
    pull_d = {8{ctrl_q.pullup_en}} & dir_q;
    schm_d = 8'h00;
    schm_d[gpio_port_pkg::EXT_PIN] = ctrl_q.ext_int_sel;
    schm_d[gpio_port_pkg::PCLK_PIN]  = prog;
    schm_d[gpio_port_pkg::PDATA_PIN] = prog;
    pclk_d = prog && pins[gpio_port_pkg::PCLK_PIN];
    pdat_d = prog && pins[gpio_port_pkg::PDATA_PIN];
    if (prog) begin
      // programming logic owns both pins, latches stay untouched
      oe_d[gpio_port_pkg::PCLK_PIN]    = 1'b0;
      pull_d[gpio_port_pkg::PCLK_PIN]  = 1'b0;
      oe_d[gpio_port_pkg::PDATA_PIN]   = prog_data_oe;
      out_d[gpio_port_pkg::PDATA_PIN]  = prog_data_drive;
      pull_d[gpio_port_pkg::PDATA_PIN] = 1'b0;
    end
    irq_d = |(stat_q & mask_q);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      latch_q   <= gpio_port_pkg::LATCH_RESET;
      dir_q     <= gpio_port_pkg::DIR_RESET;
      ctrl_q    <= gpio_port_pkg::CTRL_RESET;
      stat_q    <= gpio_port_pkg::IRQ_RESET;
      mask_q    <= gpio_port_pkg::IRQ_RESET;
      prev_q    <= pins; // follows pins in reset, no false change at release
      aw_full_q <= 1'b0;
      aw_addr_q <= '0;
      w_full_q  <= 1'b0;
      w_data_q  <= 8'h00;
      w_en_q    <= 1'b0;
      bvalid_q  <= 1'b0;
      bresp_q   <= gpio_port_pkg::RESP_OKAY;
      rvalid_q  <= 1'b0;
      rresp_q   <= gpio_port_pkg::RESP_OKAY;
      rdata_q   <= 32'h0000_0000;
      awready_q <= 1'b0;
      wready_q  <= 1'b0;
      arready_q <= 1'b0;
      out_q     <= 8'h00;
      oe_q      <= 8'h00;
      pull_q    <= 8'h00;
      schm_q    <= 8'h00;
      pclk_q    <= 1'b0;
      pdat_q    <= 1'b0;
      irq_q     <= 1'b0;
    end else begin
      latch_q   <= latch_d;
      dir_q     <= dir_d;
      ctrl_q    <= ctrl_d;
      stat_q    <= stat_d;
      mask_q    <= mask_d;
      prev_q    <= pins;
      aw_full_q <= aw_full_d;
      aw_addr_q <= aw_addr_d;
      w_full_q  <= w_full_d;
      w_data_q  <= w_data_d;
      w_en_q    <= w_en_d;
      bvalid_q  <= bvalid_d;
      bresp_q   <= bresp_d;
      rvalid_q  <= rvalid_d;
      rresp_q   <= rresp_d;
      rdata_q   <= rdata_d;
      awready_q <= awready_d;
      wready_q  <= wready_d;
      arready_q <= arready_d;
      out_q     <= out_d;
      oe_q      <= oe_d;
      pull_q    <= pull_d;
      schm_q    <= schm_d;
      pclk_q    <= pclk_d;
      pdat_q    <= pdat_d;
      irq_q     <= irq_d;
    end
  end

  assign s_axi_awready = awready_q;
  assign s_axi_wready  = wready_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = arready_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign pad_out       = out_q;
  assign pad_oe        = oe_q;
  assign pad_pullup    = pull_q;
  assign pad_schmitt   = schm_q;
  assign prog_clock    = pclk_q;
  assign prog_data     = pdat_q;
  assign irq           = irq_q;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  logic ar_port;
  assign ar_port = s_axi_arvalid && arready_q && s_axi_araddr == gpio_port_pkg::OFS_PORT;

  chk_port_reads_pins: assert property (ar_port |=> s_axi_rdata[7:0] == $past(pins))
    else $error("port read did not return pin levels");
  chk_port_write_latch: assert property (do_wr && w_en_q
    && aw_addr_q == gpio_port_pkg::OFS_PORT
    |=> ##1 pad_out[5:0] == $past(w_data_q[5:0], 2))
    else $error("port write did not reach the latch");
  chk_bitop_rmw: assert property (do_wr && w_en_q
    && aw_addr_q == gpio_port_pkg::OFS_BITOP
    |=> latch_q[$past(bit_idx)] == $past(w_data_q[gpio_port_pkg::BITOP_VAL]))
    else $error("bit operation missed its bit");
  chk_input_relatch: assert property (do_wr && w_en_q
    && aw_addr_q == gpio_port_pkg::OFS_BITOP
    && bit_idx != 3'h0 |=> latch_q[0] == $past(pins[0]))
    else $error("bit operation did not copy pin level");
  chk_clear_six_high: assert property (do_wr && w_en_q
    && aw_addr_q == gpio_port_pkg::OFS_BITOP
    && bit_idx == 3'h6 && pins[7] |=> latch_q[7])
    else $error("pin seven latch not set high");
  chk_dir_drive: assert property (!prog ##1 !prog |-> oe_q == ~$past(dir_q))
    else $error("output enable disagrees with direction");
  chk_pullup_inputs: assert property (!prog ##1 !prog
    |-> pull_q == ({8{$past(ctrl_q.pullup_en)}} & $past(dir_q)))
    else $error("pull-up applied to a non-input pin");
  chk_schmitt_sel: assert property (schm_q[0] == $past(ctrl_q.ext_int_sel)
    && schm_q[7:6] == {2{$past(prog)}})
    else $error("schmitt selection wrong");
  chk_change_sets: assert property (|((pins[7:4] ^ prev_q[7:4]) & dir_q[7:4])
    |=> stat_q.change
    ##1 irq == ($past(mask_q.change) || ($past(stat_q.ext) && $past(mask_q.ext))))
    else $error("pin change did not raise status");
  chk_prog_clock: assert property (prog && pins[6] |=> prog_clock)
    else $error("programming clock not passed");
  chk_ext_edge: assert property (ctrl_q.ext_int_sel && ext_edge |=> stat_q.ext)
    else $error("external edge lost");

  cov_bitop: cover property (do_wr && aw_addr_q == gpio_port_pkg::OFS_BITOP);
  cov_irq: cover property ($rose(irq));
  cov_prog: cover property (prog ##1 prog_clock);
endmodule
`default_nettype wire

/* File: logic/gpio_port_pkg.sv */
`default_nettype none
package gpio_port_pkg;
  localparam int unsigned ADDR_W = 5;
  localparam int unsigned PINS   = 8;

  // byte offsets of the register words
  localparam logic [ADDR_W-1:0] OFS_PORT   = 5'h00;
  localparam logic [ADDR_W-1:0] OFS_DIR    = 5'h04;
  localparam logic [ADDR_W-1:0] OFS_CTRL   = 5'h08;
  localparam logic [ADDR_W-1:0] OFS_BITOP  = 5'h0C;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 5'h10;
  localparam logic [ADDR_W-1:0] OFS_MASK   = 5'h14;

  // reset values
  localparam logic [7:0] DIR_RESET   = 8'hFF;
  localparam logic [7:0] LATCH_RESET = 8'h00;

  // pin positions
  localparam int unsigned EXT_PIN   = 0;
  localparam int unsigned PCLK_PIN  = 6;
  localparam int unsigned PDATA_PIN = 7;
  localparam int unsigned CHG_LO    = 4;
  localparam int unsigned CHG_HI    = 7;

  // bit-operation word fields
  localparam int unsigned BITOP_IDX_LO = 0;
  localparam int unsigned BITOP_IDX_HI = 2;
  localparam int unsigned BITOP_VAL    = 3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic edge_rise;
    logic ext_int_sel;
    logic pullup_en;
  } ctrl_t;

  typedef struct packed {
    logic change;
    logic ext;
  } irq_t;

  localparam ctrl_t CTRL_RESET = 3'h0;
  localparam irq_t  IRQ_RESET  = 2'h0;
endpackage
`default_nettype wire

/* File: logic/pin_sync3.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_sync3 #(
  parameter int unsigned W = 9
) (
  input  wire logic         aclk,
  input  wire logic         aresetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);
  logic [W-1:0] f1_q, f2_q, f3_q, out_q;
  logic [W-1:0] out_d;

  // a change counts only once the second and third stage agree
  always_comb begin
    out_d = out_q;
    for (int i = 0; i < W; i++) begin
      if (f2_q[i] == f3_q[i]) begin
        out_d[i] = f3_q[i];
      end
    end
  end

  // chain runs through reset so release shows the true level, no false edge
  always_ff @(posedge aclk) begin
    f1_q <= async_in;
    f2_q <= f1_q;
    f3_q <= f2_q;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      out_q <= f3_q;
    end else begin
      out_q <= out_d;
    end
  end

  assign sync_out = out_q;
endmodule
`default_nettype wire

/* File: test/pin_world.sv */
`timescale 1ns/100ps
`default_nettype none
module pin_world (
  input  wire logic       aclk,
  input  wire logic [7:0] pad_out,
  input  wire logic [7:0] pad_oe,
  input  wire logic [7:0] pad_pullup,
  input  wire logic [7:0] ext_val,
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_pu,
  output logic      [7:0] pad_in
);
  logic [7:0] float_q;
  logic [7:0] drv;
  // outside drivers back off where the device drives
  assign drv = ext_en & ~pad_oe;
  // an open pin wanders, so no check can lean on a stale level
  initial float_q = 8'h00;
  always @(posedge aclk) float_q <= ~float_q;
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      if (pad_oe[i]) pad_in[i] = pad_out[i];
      else if (drv[i]) pad_in[i] = ext_val[i];
      else if (pad_pullup[i] | ext_pu[i]) pad_in[i] = 1'b1;
      else pad_in[i] = float_q[i];
    end
  end
endmodule
`default_nettype wire

/* File: test/tb_top.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic        s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [4:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [7:0]  pad_in, pad_out, pad_oe, pad_pullup, pad_schmitt;
  logic [7:0]  ext_val, ext_en, ext_pu;
  logic        prog_mode_in, prog_clock, prog_data, irq;
  logic        prog_data_drive, prog_data_oe;
  int          n_mismatch = 0;
  int          checks = 0;

  always #5 aclk = ~aclk;

  bidir_port_b_pins uut (
    .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_awaddr, .s_axi_wvalid,
    .s_axi_wready, .s_axi_wdata, .s_axi_wstrb, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_arvalid, .s_axi_arready, .s_axi_araddr, .s_axi_rvalid,
    .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .pad_in, .pad_out, .pad_oe,
    .pad_pullup, .pad_schmitt, .prog_mode_in, .prog_data_drive,
    .prog_data_oe, .prog_clock, .prog_data, .irq
  );
  pin_world far (.aclk, .pad_out, .pad_oe, .pad_pullup, .ext_val, .ext_en, .ext_pu, .pad_in);

  task automatic test_done;
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic tmo;
    cmp(32'h0, 32'h1);
    test_done();
  endtask

  // sync chain plus register stage is under 8 edges
  task automatic settle;
    repeat (8) @(posedge aclk);
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    int n;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) break;
    end
    if (n == 50) tmo();
    cmp(s_axi_bresp, gpio_port_pkg::RESP_OKAY);
    s_axi_bready <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] a, input logic [7:0] e,
                      input logic [1:0] er = gpio_port_pkg::RESP_OKAY);
    int n;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) break;
    end
    if (n == 50) tmo();
    cmp(s_axi_rdata, {24'h0, e});
    cmp(s_axi_rresp, er);
    s_axi_rready <= 1'b0;
  endtask

  task automatic t_reset;
    rchk(gpio_port_pkg::OFS_DIR, 8'hFF);
    rchk(gpio_port_pkg::OFS_BITOP, 8'h00);
    rchk(gpio_port_pkg::OFS_CTRL, 8'h00);
    rchk(gpio_port_pkg::OFS_STATUS, 8'h00);
    rchk(gpio_port_pkg::OFS_MASK, 8'h00);
    rchk(5'h18, 8'h00, gpio_port_pkg::RESP_SLVERR);
    cmp(pad_oe, 8'h00);
  endtask

  task automatic t_latch;
    wr(gpio_port_pkg::OFS_PORT, 8'hA5);
    settle();
    rchk(gpio_port_pkg::OFS_PORT, 8'h3C);
    rchk(gpio_port_pkg::OFS_BITOP, 8'hA5);
    wr(gpio_port_pkg::OFS_DIR, 8'h00);
    settle();
    cmp(pad_oe, 8'hFF);
    cmp(pad_out, 8'hA5);
    rchk(gpio_port_pkg::OFS_PORT, 8'hA5);
  endtask

  // two clears in a row on a half-input port, pins 7:6 pulled up outside
  task automatic t_rmw;
    ext_en <= 8'h30;
    ext_val <= 8'h00;
    ext_pu <= 8'hC0;
    wr(gpio_port_pkg::OFS_DIR, 8'hF0);
    wr(gpio_port_pkg::OFS_PORT, 8'h05);
    settle();
    wr(gpio_port_pkg::OFS_BITOP, 8'h0D);
    rchk(gpio_port_pkg::OFS_BITOP, 8'hE5);
    wr(gpio_port_pkg::OFS_BITOP, 8'h07);
    rchk(gpio_port_pkg::OFS_BITOP, 8'h45);
    wr(gpio_port_pkg::OFS_BITOP, 8'h06);
    rchk(gpio_port_pkg::OFS_BITOP, 8'h85);
    wr(gpio_port_pkg::OFS_DIR, 8'h70);
    wr(gpio_port_pkg::OFS_DIR, 8'h30);
    settle();
    cmp(pad_oe, 8'hCF);
    cmp(pad_out, 8'h85);
    rchk(gpio_port_pkg::OFS_PORT, 8'h85);
  endtask

  task automatic t_pullup;
    ext_en <= 8'h00;
    ext_pu <= 8'h00;
    wr(gpio_port_pkg::OFS_CTRL, 8'h01);
    wr(gpio_port_pkg::OFS_DIR, 8'hF0);
    settle();
    cmp(pad_pullup, 8'hF0);
    rchk(gpio_port_pkg::OFS_PORT, 8'hF5);
    wr(gpio_port_pkg::OFS_DIR, 8'h30);
    settle();
    cmp(pad_pullup, 8'h30);
    ext_en <= 8'hFF;
    wr(gpio_port_pkg::OFS_CTRL, 8'h00);
    settle();
    cmp(pad_pullup, 8'h00);
  endtask

  task automatic t_irq;
    ext_val <= 8'h00;
    wr(gpio_port_pkg::OFS_DIR, 8'hFF);
    wr(gpio_port_pkg::OFS_CTRL, 8'h06);
    wr(gpio_port_pkg::OFS_MASK, 8'h03);
    settle();
    wr(gpio_port_pkg::OFS_STATUS, 8'h03);
    settle();
    cmp(pad_schmitt[0], 1'b1);
    cmp(irq, 1'b0);
    ext_val <= 8'h01;
    settle();
    cmp(irq, 1'b1);
    rchk(gpio_port_pkg::OFS_STATUS, 8'h01);
    wr(gpio_port_pkg::OFS_STATUS, 8'h01);
    // pin 1 lies outside the change group and must stay silent
    for (int i = 1; i < 8; i++) begin
      if (i == 2) i = 4;
      ext_val[i] <= ~ext_val[i];
      settle();
      rchk(gpio_port_pkg::OFS_STATUS, (i >= 4) ? 8'h02 : 8'h00);
      cmp(irq, i >= 4);
      wr(gpio_port_pkg::OFS_STATUS, 8'h02);
    end
    // falling-edge selection on pin zero
    wr(gpio_port_pkg::OFS_CTRL, 8'h02);
    ext_val[0] <= 1'b0;
    settle();
    rchk(gpio_port_pkg::OFS_STATUS, 8'h01);
    cmp(irq, 1'b1);
    wr(gpio_port_pkg::OFS_STATUS, 8'h01);
    wr(gpio_port_pkg::OFS_MASK, 8'h01);
    ext_val[4] <= 1'b0;
    settle();
    rchk(gpio_port_pkg::OFS_STATUS, 8'h02);
    cmp(irq, 1'b0);
    wr(gpio_port_pkg::OFS_CTRL, 8'h00);
    settle();
    cmp(pad_schmitt[0], 1'b0);
  endtask

  task automatic t_prog;
    ext_val <= 8'hC0;
    prog_mode_in <= 1'b1;
    settle();
    cmp({prog_clock, prog_data}, 2'b11);
    cmp(pad_schmitt[7:6], 2'b11);
    ext_val <= 8'h00;
    settle();
    cmp({prog_clock, prog_data}, 2'b00);
    prog_data_drive <= 1'b1;
    prog_data_oe <= 1'b1;
    settle();
    cmp({pad_oe[7], pad_out[7], prog_data}, 3'b111);
    prog_data_oe <= 1'b0;
    prog_mode_in <= 1'b0;
    settle();
    cmp(pad_schmitt[7:6], 2'b00);
  endtask

  initial begin
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
    s_axi_awaddr = 5'h00;
    s_axi_araddr = 5'h00;
    s_axi_wdata = 32'h0;
    s_axi_wstrb = 4'hF;
    prog_mode_in = 1'b0;
    prog_data_drive = 1'b0;
    prog_data_oe = 1'b0;
    ext_val = 8'h3C;
    ext_en = 8'hFF;
    ext_pu = 8'h00;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    t_reset();
    t_latch();
    t_rmw();
    t_pullup();
    t_irq();
    t_prog();
    test_done();
  end
endmodule
`default_nettype wire
